// ---- inc/oswc_cfg.svh ----
`ifndef OSWC_CFG_SVH
`define OSWC_CFG_SVH

// Register byte addresses in the CPU data space.
`define OSWC_ADDR_FAST20_CTRL 20'hF00F6
`define OSWC_ADDR_STAB_STATUS 20'hFFFA2
`define OSWC_ADDR_STAB_SEL 20'hFFFA3

// Reset values.
`define OSWC_RST_STAB_SEL 3'h7
`define OSWC_RST_FAST20_RUN 1'h0
`define OSWC_RST_FAST20_SEL 1'h0
`define OSWC_RST_STATUS 8'h00

// Field positions in the fast oscillator control register.
`define OSWC_BIT_FAST20_RUN 0
`define OSWC_BIT_FAST20_SEL 2
`define OSWC_BIT_FAST20_FLAG 3

// Width of the wait select field and of the edge counter.
`define OSWC_SEL_W 3
`define OSWC_CNT_W 19

// Break count at a source change; no core clock source is enabled for this many cycles plus one.
`define OSWC_BREAK_CYC 4'h4

`endif

// ---- inc/oswc_pkg.sv ----
package oswc_pkg;

    // CPU access to the special function registers.
    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } oswc_sfr_req_type;

    // Core clock source switch sequence, one-hot.
    typedef enum logic [3:0] {
        SRC_USUAL = 4'h1,
        SRC_TO_F20 = 4'h2,
        SRC_F20 = 4'h4,
        SRC_TO_USUAL = 4'h8
    } oswc_src_type;

    // Stabilization counter state, one-hot.
    typedef enum logic [2:0] {
        STB_IDLE = 3'h1,
        STB_COUNT = 3'h2,
        STB_DONE = 3'h4
    } oswc_stb_type;

endpackage

// ---- rtl/oswc_ctrl.sv ----
`timescale 1ns/1ps
`include "oswc_cfg.svh"
// Contract
// - CPU on the crystal is held after STOP release until the wait ends.
// - Reset loads the wait select register with 07H, the longest wait.
// - Codes 000..111 wait 2^8,9,10,11,13,15,17,18 cycles; bits 7..3 zero.
// - Status counts only up to the selected wait; lower bits stay 0.
// - Counting starts only once the main oscillator really oscillates.
// - Reset clears the fast oscillator control register to 00H.
// - Run bit 0 stops the fast oscillator at 0, runs it at 1.
// - Select bit 2 feeds core clock from usual source or fast oscillator.
// - Read-only bit 3 is 1 only while core clock runs on fast oscillator.
// - Status counter clears on reset, STOP, and main oscillator stop.
// - Status bits set one by one from the shortest wait and stay set.
module oswc_ctrl
    import oswc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // CPU register access.
    input oswc_sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    // Main crystal oscillator.
    input wire logic main_crystal_clock,
    input wire logic main_osc_running,
    input wire logic main_osc_stop_bit,
    input wire logic cpu_on_main_clk,
    // Standby control.
    input wire logic stop_exec,
    input wire logic stop_release,
    output logic cpu_hold,
    // Fast internal oscillator and core clock source.
    input wire logic fast20_osc_ready,
    output logic fast20_osc_run,
    output logic core_src_usual_en,
    output logic core_src_fast20_en
);

    localparam int N_STEP = 8;

    logic [`OSWC_SEL_W-1:0] sel_q;
    logic run_q;
    logic clk_sel_q;
    logic flag_q;
    logic [7:0] status_q;
    logic [`OSWC_CNT_W-1:0] cnt_q;
    oswc_stb_type stb_q;
    oswc_src_type src_q;
    logic [3:0] brk_q;
    logic [7:0] rdata_q;
    logic hit_q;
    logic hold_q;
    logic [2:0] xs_q;
    logic [2:0] os_q;
    logic [2:0] fs_q;
    logic x_lvl_q;
    logic o_lvl_q;
    logic f_lvl_q;
    logic stop_bit_q;
    logic x_edge;
    logic start_evt;
    logic clear_evt;
    logic [N_STEP-1:0] reached;
    logic [N_STEP-1:0] allowed;
    logic sel_reached;
    logic wr_ctrl;
    logic wr_sel;

    // Wait length in main oscillator cycles for each status step.
    function automatic logic [`OSWC_CNT_W-1:0] step_len(input int k);
        logic [`OSWC_CNT_W-1:0] one;
        one = `OSWC_CNT_W'(1);
        case (k)
            0: step_len = one << 8;
            1: step_len = one << 9;
            2: step_len = one << 10;
            3: step_len = one << 11;
            4: step_len = one << 13;
            5: step_len = one << 15;
            6: step_len = one << 17;
            default: step_len = one << 18;
        endcase
    endfunction

    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == `OSWC_ADDR_FAST20_CTRL);
    assign wr_sel = sfr_req.wr && (sfr_req.addr == `OSWC_ADDR_STAB_SEL);

    // Pins from the oscillators are asynchronous to the core clock. A new
    // level is accepted only once the second and third stages agree.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xs_q <= 3'h0;
            os_q <= 3'h0;
            fs_q <= 3'h0;
        end else begin
            xs_q <= {xs_q[1:0], main_crystal_clock};
            os_q <= {os_q[1:0], main_osc_running};
            fs_q <= {fs_q[1:0], fast20_osc_ready};
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            x_lvl_q <= 1'h0;
            o_lvl_q <= 1'h0;
            f_lvl_q <= 1'h0;
        end else begin
            if (xs_q[1] == xs_q[2]) begin
                x_lvl_q <= xs_q[2];
            end
            if (os_q[1] == os_q[2]) begin
                o_lvl_q <= os_q[2];
            end
            if (fs_q[1] == fs_q[2]) begin
                f_lvl_q <= fs_q[2];
            end
        end
    end

    // The crystal must be slower than a quarter of the core clock to count.
    assign x_edge = (xs_q[1] == xs_q[2]) && xs_q[2] && !x_lvl_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stop_bit_q <= 1'h1;
        end else begin
            stop_bit_q <= main_osc_stop_bit;
        end
    end

    assign clear_evt = stop_exec || main_osc_stop_bit;
    assign start_evt = stop_release || (stop_bit_q && !main_osc_stop_bit);

    // Wait select register.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sel_q <= `OSWC_RST_STAB_SEL;
        end else if (wr_sel) begin
            sel_q <= sfr_req.wdata[`OSWC_SEL_W-1:0];
        end
    end

    // Fast oscillator control bits; bit 3 and the zero bits are not stored.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_q <= `OSWC_RST_FAST20_RUN;
            clk_sel_q <= `OSWC_RST_FAST20_SEL;
        end else if (wr_ctrl) begin
            run_q <= sfr_req.wdata[`OSWC_BIT_FAST20_RUN];
            clk_sel_q <= sfr_req.wdata[`OSWC_BIT_FAST20_SEL];
        end
    end

    assign fast20_osc_run = run_q;

    // Step k has elapsed once the edge count reaches its length, and it may
    // show only if it lies within the selected wait.
    genvar gi;
    generate
        for (gi = 0; gi < N_STEP; gi++) begin : g_step
            assign reached[gi] = cnt_q >= step_len(gi);
            assign allowed[gi] = gi <= int'(sel_q);
        end
    endgenerate

    assign sel_reached = cnt_q >= step_len(int'(sel_q));

    // Stabilization sequencer.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stb_q <= STB_IDLE;
        end else if (clear_evt) begin
            stb_q <= STB_IDLE;
        end else begin
            case (stb_q)
                STB_IDLE: begin
                    if (start_evt) begin
                        stb_q <= STB_COUNT;
                    end
                end
                STB_COUNT: begin
                    if (sel_reached) begin
                        stb_q <= STB_DONE;
                    end
                end
                STB_DONE: begin
                    if (start_evt) begin
                        stb_q <= STB_COUNT;
                    end
                end
                default: stb_q <= STB_IDLE;
            endcase
        end
    end

    // Edge counter; the start-up delay before oscillation is not counted.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (clear_evt || start_evt) begin
            cnt_q <= '0;
        end else if (stb_q == STB_COUNT && o_lvl_q && x_edge) begin
            cnt_q <= cnt_q + `OSWC_CNT_W'(1);
        end
    end

    // Status bits, shortest wait in bit 7, set in order and kept.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_q <= `OSWC_RST_STATUS;
        end else if (clear_evt || start_evt) begin
            status_q <= `OSWC_RST_STATUS;
        end else begin
            for (int k = 0; k < N_STEP; k++) begin
                if (reached[k] && allowed[k]) begin
                    status_q[N_STEP-1-k] <= 1'h1;
                end
            end
        end
    end

    // Automatic CPU hold only when the crystal drives the CPU; on the
    // internal clock software polls the status register instead.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 1'h0;
        end else if (stop_release && cpu_on_main_clk) begin
            hold_q <= 1'h1;
        end else if (stb_q == STB_DONE || stb_q == STB_IDLE) begin
            hold_q <= 1'h0;
        end
    end

    assign cpu_hold = hold_q;

    // Break-before-make source change: the old source is released and a
    // few idle cycles pass before the new one is enabled, so no runt pulse
    // reaches the core. The fast source is taken only once it is ready.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            src_q <= SRC_USUAL;
            brk_q <= 4'h0;
        end else begin
            case (src_q)
                SRC_USUAL: begin
                    if (clk_sel_q && run_q && f_lvl_q) begin
                        src_q <= SRC_TO_F20;
                        brk_q <= `OSWC_BREAK_CYC;
                    end
                end
                SRC_TO_F20: begin
                    if (brk_q != 4'h0) begin
                        brk_q <= brk_q - 4'h1;
                    end else begin
                        src_q <= SRC_F20;
                    end
                end
                SRC_F20: begin
                    if (!clk_sel_q || !run_q) begin
                        src_q <= SRC_TO_USUAL;
                        brk_q <= `OSWC_BREAK_CYC;
                    end
                end
                SRC_TO_USUAL: begin
                    if (brk_q != 4'h0) begin
                        brk_q <= brk_q - 4'h1;
                    end else begin
                        src_q <= SRC_USUAL;
                    end
                end
                default: begin
                    src_q <= SRC_USUAL;
                    brk_q <= 4'h0;
                end
            endcase
        end
    end

    assign core_src_usual_en = (src_q == SRC_USUAL);
    assign core_src_fast20_en = (src_q == SRC_F20);

    // The flag follows the finished switch, not the select bit.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flag_q <= 1'h0;
        end else begin
            flag_q <= (src_q == SRC_F20);
        end
    end

    // Read data is registered; unused bits read as zero.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
            hit_q <= 1'h0;
        end else begin
            rdata_q <= 8'h00;
            hit_q <= 1'h0;
            if (sfr_req.rd) begin
                case (sfr_req.addr)
                    `OSWC_ADDR_STAB_SEL: begin
                        rdata_q <= {5'h00, sel_q};
                        hit_q <= 1'h1;
                    end
                    `OSWC_ADDR_STAB_STATUS: begin
                        rdata_q <= status_q;
                        hit_q <= 1'h1;
                    end
                    `OSWC_ADDR_FAST20_CTRL: begin
                        rdata_q <= {4'h0, flag_q, clk_sel_q,
                            1'h0, run_q};
                        hit_q <= 1'h1;
                    end
                    default: begin
                        rdata_q <= 8'h00;
                        hit_q <= 1'h0;
                    end
                endcase
            end
        end
    end

    assign sfr_rdata = rdata_q;
    assign sfr_hit = hit_q;

endmodule

// ---- verification/oswc_ctrl_assertions.sv ----
`timescale 1ns/1ps
`include "oswc_cfg.svh"
module oswc_ctrl_assertions
    import oswc_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rstn,
    // Register access.
    input oswc_sfr_req_type sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    // Standby.
    input wire logic cpu_on_main_clk,
    input wire logic stop_release,
    input wire logic cpu_hold,
    // Clock sources.
    input wire logic fast20_osc_run,
    input wire logic core_src_usual_en,
    input wire logic core_src_fast20_en
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    wire ctl_hit = sfr_req.addr == `OSWC_ADDR_FAST20_CTRL;
    wire ctl_wr = sfr_req.wr && ctl_hit;
    wire ctl_rd = sfr_req.rd && ctl_hit;
    // Neither source may drive the core clock while it changes hands.
    sequence s_gap;
        (!core_src_usual_en && !core_src_fast20_en) [*5];
    endsequence
    AST_IDLE_RDATA: assert property (
        !$past(sfr_req.rd) |-> sfr_rdata == 8'h00 && !sfr_hit)
        else $error("read data not idle");
    AST_RUN_WRITE: assert property (
        ctl_wr |=> fast20_osc_run == $past(sfr_req.wdata[0]))
        else $error("run bit not written");
    AST_RUN_HOLD: assert property (
        !ctl_wr |=> $stable(fast20_osc_run))
        else $error("run bit changed without write");
    AST_ONE_SRC: assert property (
        !(core_src_usual_en && core_src_fast20_en))
        else $error("two core clock sources");
    AST_TO_F20: assert property (
        $fell(core_src_usual_en) |-> s_gap ##1 core_src_fast20_en)
        else $error("bad switch to fast source");
    AST_TO_USUAL: assert property (
        $fell(core_src_fast20_en) |-> s_gap ##1 core_src_usual_en)
        else $error("bad switch to usual source");
    AST_HOLD_CAUSE: assert property (
        $rose(cpu_hold) |-> $past(stop_release) && $past(cpu_on_main_clk))
        else $error("hold without release on main clock");
    AST_NO_HOLD: assert property (
        stop_release && !cpu_on_main_clk && !cpu_hold |=> !cpu_hold)
        else $error("hold on internal clock");
    AST_CTL_READ: assert property (
        ctl_rd |=> sfr_hit && sfr_rdata[7:4] == 4'h0 && !sfr_rdata[1]
            && sfr_rdata[3] == $past(core_src_fast20_en, 2)
            && sfr_rdata[0] == $past(fast20_osc_run))
        else $error("bad control read");
endmodule
bind oswc_ctrl oswc_ctrl_assertions u_oswc_ctrl_assertions (
    .clock(clock), .rstn(rstn), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .cpu_on_main_clk(cpu_on_main_clk), .stop_release(stop_release),
    .cpu_hold(cpu_hold), .fast20_osc_run(fast20_osc_run),
    .core_src_usual_en(core_src_usual_en),
    .core_src_fast20_en(core_src_fast20_en)
);

// ---- verification/test_osc_stab_wait_and_fast_osc_ctrl.sv ----
`timescale 1ns/1ps
`include "oswc_cfg.svh"
module test_osc_stab_wait_and_fast_osc_ctrl
    import oswc_pkg::*;
;
    localparam logic [19:0] A_CTL = `OSWC_ADDR_FAST20_CTRL;
    localparam logic [19:0] A_STS = `OSWC_ADDR_STAB_STATUS;
    localparam logic [19:0] A_SEL = `OSWC_ADDR_STAB_SEL;
    logic clock = 1'b0, rstn = 1'b0, xtal = 1'b0, xrun = 1'b0;
    logic stop_bit = 1'b0, on_main = 1'b0, stop_exec = 1'b0;
    logic stop_rel = 1'b0, f20_ready = 1'b0;
    oswc_sfr_req_type req = '0;
    logic [7:0] rdata;
    logic hit, cpu_hold, run, usual_en, f20_en;
    int n_fail = 0, n_compared = 0;
    always #20 clock = ~clock;
    // Crystal runs at a sixth of the core clock, inside the sampling limit.
    always #120 xtal = ~xtal;
    oswc_ctrl u_oswc_ctrl (
        .clock(clock), .rstn(rstn), .sfr_req(req), .sfr_rdata(rdata),
        .sfr_hit(hit), .main_crystal_clock(xtal), .main_osc_running(xrun),
        .main_osc_stop_bit(stop_bit), .cpu_on_main_clk(on_main),
        .stop_exec(stop_exec), .stop_release(stop_rel),
        .cpu_hold(cpu_hold), .fast20_osc_ready(f20_ready),
        .fast20_osc_run(run), .core_src_usual_en(usual_en),
        .core_src_fast20_en(f20_en)
    );
    task step(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [19:0] a, input logic [7:0] d);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        step();
        req.wr = 1'b0;
        step();
    endtask
    // Expected value carries the hit flag above the data byte.
    task rd_chk(input logic [19:0] a, input logic [8:0] exp);
        req.addr = a;
        req.rd = 1'b1;
        step();
        req.rd = 1'b0;
        check({hit, rdata}, exp);
        step();
    endtask
    task t_reset;
        rd_chk(A_CTL, 9'h100);
        rd_chk(A_SEL, 9'h107);
        rd_chk(A_STS, 9'h100);
        rd_chk(20'h00000, 9'h000);
        $display("reset test done");
    endtask
    task t_regs;
        wr(A_SEL, 8'hFD);
        rd_chk(A_SEL, 9'h105);
        wr(A_CTL, 8'hFA);
        rd_chk(A_CTL, 9'h100);
        wr(A_STS, 8'hFF);
        rd_chk(A_STS, 9'h100);
        wr(A_CTL, 8'h01);
        step(2500);
        wr(A_CTL, 8'h05);
        step(20);
        rd_chk(A_CTL, 9'h105);
        check(usual_en, 1'b1);
        $display("register test done");
    endtask
    task t_switch;
        int i;
        f20_ready = 1'b1;
        for (i = 0; i < 40 && f20_en !== 1'b1; i++) step();
        check({usual_en, f20_en}, 2'h1);
        // The flag follows the finished switch one cycle later.
        step();
        rd_chk(A_CTL, 9'h10D);
        wr(A_CTL, 8'h01);
        for (i = 0; i < 40 && usual_en !== 1'b1; i++) step();
        check({usual_en, f20_en}, 2'h2);
        rd_chk(A_CTL, 9'h101);
        wr(A_CTL, 8'h00);
        check(run, 1'b0);
        $display("switch test done");
    endtask
    task t_hold;
        int n;
        wr(A_SEL, 8'h00);
        xrun = 1'b1;
        on_main = 1'b1;
        stop_rel = 1'b1;
        step();
        stop_rel = 1'b0;
        check(cpu_hold, 1'b1);
        n = 0;
        while (cpu_hold === 1'b1 && n < 3000) begin
            step();
            n++;
        end
        check(n > 1500 && n < 1600, 1'b1);
        on_main = 1'b0;
        rd_chk(A_STS, 9'h180);
        stop_exec = 1'b1;
        step();
        stop_exec = 1'b0;
        rd_chk(A_STS, 9'h100);
        $display("hold test done");
    endtask
    task t_start;
        wr(A_SEL, 8'h01);
        xrun = 1'b0;
        stop_bit = 1'b1;
        step(2);
        stop_bit = 1'b0;
        stop_rel = 1'b1;
        step();
        stop_rel = 1'b0;
        check(cpu_hold, 1'b0);
        step(1700);
        rd_chk(A_STS, 9'h100);
        xrun = 1'b1;
        step(1700);
        rd_chk(A_STS, 9'h180);
        step(1700);
        rd_chk(A_STS, 9'h1C0);
        stop_bit = 1'b1;
        step(2);
        rd_chk(A_STS, 9'h100);
        $display("start test done");
    endtask
    task give_verdict;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1 rstn = 1'b1;
        t_reset();
        t_regs();
        t_switch();
        t_hold();
        t_start();
        give_verdict();
    end
    // About three times the expected run length.
    initial begin
        #1000000;
        n_fail++;
        give_verdict();
    end
endmodule
